// *** bench/mfp_checker.sv ***
`timescale 1ns/1ns
`default_nettype none
// port-level checks on the pin controller
module mfp_checker (
    // clock and reset
    input wire logic        clk_sys_in,
    input wire logic        reset_n_in,
    // apb
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic [7:0]  paddr_in,
    input wire logic        pready_out,
    input wire logic        pslverr_out,
    // pins and framer side
    input wire logic [1:0]  serial_mode_in,
    input wire logic        power_down_n_in,
    input wire logic [7:0]  mf_pins_in,
    input wire logic [7:0]  mf_pins_out,
    input wire logic [7:0]  mf_pins_oe_n_out,
    input wire logic [3:0]  rx_parallel_bits_in,
    input wire logic        parallel_out_bit_one_out,
    input wire logic [15:0] control_word_out,
    input wire logic        calibrating_out,
    input wire logic        power_down_out
);
    logic [1:0]  mode_r;
    logic [2:0]  quiet_r;
    logic [3:0]  sel_low_r;
    logic [10:0] cal_len_r;
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!reset_n_in);
    // cycles since a mode change, select held low, calibration length
    always_ff @(posedge clk_sys_in) begin
        mode_r <= serial_mode_in;
        if (!reset_n_in || mode_r != serial_mode_in) quiet_r <= 3'h0;
        else if (quiet_r != 3'h7) quiet_r <= quiet_r + 3'h1;
        if (!reset_n_in || mf_pins_in[3]) sel_low_r <= 4'h0;
        else if (sel_low_r != 4'hF) sel_low_r <= sel_low_r + 4'h1;
        if (!reset_n_in || !calibrating_out || power_down_out) cal_len_r <= 11'h000;
        else cal_len_r <= cal_len_r + 11'h001;
    end
    ready_one_cycle_a: assert property (psel_in && !penable_in |=> pready_out ##1 !pready_out)
        else $error("apb ready not a single zero-wait pulse");
    unmapped_error_a: assert property (psel_in && !penable_in
        && (paddr_in[1:0] != 2'h0 || paddr_in > 8'h0C) |=> pslverr_out && pready_out)
        else $error("unmapped offset without error response");
    pin_five_data_a: assert property (quiet_r == 3'h7 && serial_mode_in != 2'h3
        |=> !mf_pins_oe_n_out[4] && mf_pins_out[4] == $past(rx_parallel_bits_in[1]))
        else $error("pin five does not show output bit two");
    bit_one_out_a: assert property ($past(reset_n_in)
        |-> parallel_out_bit_one_out == $past(rx_parallel_bits_in[0]))
        else $error("output bit one not following the sub-frame");
    mask_quiet_a: assert property (quiet_r == 3'h7 && serial_mode_in == 2'h3
        && control_word_out[0] && $past(control_word_out[0]) |-> mf_pins_oe_n_out[4])
        else $error("masked interrupt still driven");
    word_hold_a: assert property (sel_low_r > 4'h7 |-> $stable(control_word_out))
        else $error("control word changed without a select rise");
    cal_bound_a: assert property (cal_len_r <= 11'h3ED)
        else $error("calibration runs too long");
    reset_state_a: assert property (disable iff (1'b0) !reset_n_in
        |=> mf_pins_oe_n_out == 8'hFF && calibrating_out)
        else $error("reset state wrong");
    power_hold_a: assert property (!power_down_n_in [*4] |-> power_down_out)
        else $error("power-down input low without power-down state");
    // main scenarios
    cover property (!mf_pins_oe_n_out[4] && serial_mode_in == 2'h3);
    cover property ($rose(mf_pins_in[3]) && serial_mode_in == 2'h3);
    cover property ($fell(calibrating_out));
endmodule // mfp_checker
bind mfp_pin_ctrl mfp_checker u_chk (.clk_sys_in, .reset_n_in, .psel_in, .penable_in,
    .paddr_in, .pready_out, .pslverr_out, .serial_mode_in, .power_down_n_in, .mf_pins_in,
    .mf_pins_out, .mf_pins_oe_n_out, .rx_parallel_bits_in, .parallel_out_bit_one_out,
    .control_word_out, .calibrating_out, .power_down_out);
`default_nettype wire

// *** bench/mfp_ctl_host.sv ***
`timescale 1ns/1ns
`default_nettype none
// controller side of the mode four control port
module mfp_ctl_host (
    // lines towards the device
    output var logic ctl_select_out,
    output var logic ctl_clock_out,
    output var logic ctl_data_out,
    // status line from the device
    input  wire logic ctl_data_in
);
    // idle: deselected, clock parked high and still
    initial begin
        ctl_select_out = 1'b1;
        ctl_clock_out = 1'b1;
        ctl_data_out = 1'b0;
    end
    // one 16 bit frame, msb first, 80 ns clock, phase unrelated to the system clock
    task automatic xfer(input logic [15:0] w, output logic [15:0] r);
        #3;
        ctl_select_out = 1'b0;
        ctl_data_out = w[15];
        #80;
        for (int i = 15; i >= 0; i--) begin
            ctl_clock_out = 1'b0;
            r[i] = ctl_data_in;
            #40;
            ctl_clock_out = 1'b1;
            if (i > 0) ctl_data_out = w[i-1];
            #40;
        end
        ctl_select_out = 1'b1;
        ctl_data_out = ~ctl_data_out; // inverted line, no stale level
        #80;
    endtask
endmodule // mfp_ctl_host
`default_nettype wire

// *** bench/tb.sv ***
`timescale 1ns/1ns
`default_nettype none
// self-checking bench for the pin controller
module tb;
    logic        clk_sys_in, reset_n_in, psel_in, penable_in, pwrite_in, pready_out;
    logic        pslverr_out, er, power_down_n_in, mode_four_leader_in;
    logic [7:0]  paddr_in, drv, mf_pins_out, mf_pins_oe_n_out;
    logic [31:0] pwdata_in, prdata_out, rd;
    logic [1:0]  serial_mode_in, bit_clock_error_in, frame_size_out, slot_select_out;
    logic        parallel_in_bit_one_in, parallel_out_bit_one_out, conversion_valid_flag_in;
    logic [3:0]  rx_parallel_bits_in, tx_parallel_bits_out;
    logic        left_clip_flag_in, right_clip_flag_in, leader_mode_out, clock_sync_oe_n_out;
    logic        calibrating_out, power_down_out, h_sel, h_clk, h_dat;
    logic [2:0]  rate_select_out;
    logic [15:0] control_word_out, hr;
    wire  [7:0]  mf_pins_in, ext;
    int          errors, total_checks;
    // mode four: control lines from the host, pull-up on pin five
    assign ext = (serial_mode_in == 2'h3) ? {drv[7:5], 1'b1, h_sel, h_clk, h_dat, drv[0]} : drv;
    assign mf_pins_in = (mf_pins_oe_n_out & ext) | (~mf_pins_oe_n_out & mf_pins_out);
    mfp_pin_ctrl dut (.clk_sys_in, .reset_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
        .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .serial_mode_in,
        .mode_four_leader_in, .power_down_n_in, .mf_pins_in, .mf_pins_out, .mf_pins_oe_n_out,
        .parallel_in_bit_one_in, .parallel_out_bit_one_out, .rx_parallel_bits_in,
        .tx_parallel_bits_out, .conversion_valid_flag_in, .left_clip_flag_in,
        .right_clip_flag_in, .bit_clock_error_in, .leader_mode_out, .clock_sync_oe_n_out,
        .rate_select_out, .frame_size_out, .slot_select_out, .control_word_out,
        .calibrating_out, .power_down_out);
    mfp_ctl_host u_host (.ctl_select_out(h_sel), .ctl_clock_out(h_clk), .ctl_data_out(h_dat),
        .ctl_data_in(mf_pins_in[0]));
    // verdict and end of run
    task automatic summarize();
        if (errors == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer, result in rd and er
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys_in);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_sys_in);
        penable_in <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge clk_sys_in);
            if (pready_out === 1'b1) break;
        end
        rd = prdata_out;
        er = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        if (n == 20) begin
            errors++;
            summarize();
        end
    endtask
    // 125 mhz clock, also the master clock that the far side locks to
    initial begin
        clk_sys_in = 1'b0;
        forever #4 clk_sys_in = ~clk_sys_in;
    end
    // main sequence
    initial begin
        {reset_n_in, psel_in, penable_in, pwrite_in, paddr_in, pwdata_in, drv} = '0;
        {serial_mode_in, mode_four_leader_in, parallel_in_bit_one_in, rx_parallel_bits_in} = '0;
        {conversion_valid_flag_in, left_clip_flag_in, right_clip_flag_in} = '0;
        {bit_clock_error_in, errors, total_checks} = '0;
        power_down_n_in = 1'b1;
        repeat (12) @(posedge clk_sys_in);
        chk(mf_pins_oe_n_out, 8'hFF);
        chk(calibrating_out, 1'b1);
        reset_n_in <= 1'b1;
        repeat (990) @(posedge clk_sys_in);
        chk(calibrating_out, 1'b1);
        repeat (20) @(posedge clk_sys_in);
        chk(calibrating_out, 1'b0);
        // modes one to three, two pin patterns each
        for (int m = 0; m < 6; m++) begin
            @(posedge clk_sys_in);
            serial_mode_in <= m[2:1];
            drv <= m[0] ? 8'h95 : 8'h6A;
            rx_parallel_bits_in <= m[0] ? 4'hA : 4'h5;
            parallel_in_bit_one_in <= m[0];
            // released format pins need the pin release plus two sync flops
            repeat (8) @(posedge clk_sys_in);
            chk(tx_parallel_bits_out[1], drv[5]);
            chk({mf_pins_oe_n_out[4], mf_pins_out[4]}, {1'b0, rx_parallel_bits_in[1]});
            chk(slot_select_out, drv[7:6]);
            chk(tx_parallel_bits_out[0], parallel_in_bit_one_in);
            chk(parallel_out_bit_one_out, rx_parallel_bits_in[0]);
            if (m < 4) chk(tx_parallel_bits_out[3:2], drv[3:2]);
            else chk({leader_mode_out, clock_sync_oe_n_out, rate_select_out},
                {drv[3], ~drv[3], drv[3] ? drv[2:0] : 3'h0});
            if (m < 4) chk({mf_pins_oe_n_out[1:0], mf_pins_out[1:0]},
                {2'h0, rx_parallel_bits_in[2], rx_parallel_bits_in[3]});
        end
        // mode four: leader rate pins, then follower frame codes
        for (int k = 0; k < 5; k++) begin
            @(posedge clk_sys_in);
            serial_mode_in <= 2'h3;
            mode_four_leader_in <= (k < 2);
            drv <= (k == 0) ? 8'hA0 : (k == 1) ? 8'h60 : (k == 2) ? 8'hE0 : (k == 3) ? 8'h40 : 8'h00;
            repeat (6) @(posedge clk_sys_in);
            chk(leader_mode_out, k < 2);
            if (k < 2) chk(rate_select_out, drv[7:5]);
            else chk(frame_size_out, drv[5] ? 2'h2 : {1'b0, drv[6]});
            if (k == 2) chk(slot_select_out, drv[7:6]);
        end
        // control port round trip and register map
        apb(1'b1, 8'h0C, 32'h0000_A5C3);
        apb(1'b0, 8'h0C, 32'h0);
        chk(rd, 32'h0000_A5C3);
        u_host.xfer(16'h1234, hr);
        chk(hr, 16'hA5C3);
        chk(control_word_out, 16'h1234);
        apb(1'b1, 8'h08, 32'h0000_FFFF);
        apb(1'b0, 8'h08, 32'h0);
        chk(rd, 32'h0000_1234);
        apb(1'b0, 8'h10, 32'h0);
        chk(er, 1'b1);
        chk(rd, 32'h0);
        apb(1'b0, 8'h04, 32'h0);
        chk(rd, 32'h0000_0003);
        // entering range error is quiet, every event pulls the line low
        @(posedge clk_sys_in);
        bit_clock_error_in <= 2'h3;
        repeat (8) @(posedge clk_sys_in);
        chk(mf_pins_in[4], 1'b1);
        for (int e = 0; e < 5; e++) begin
            @(posedge clk_sys_in);
            case (e)
                0: conversion_valid_flag_in <= 1'b1;
                1: parallel_in_bit_one_in <= ~parallel_in_bit_one_in;
                2: left_clip_flag_in <= 1'b1;
                3: right_clip_flag_in <= 1'b1;
                default: bit_clock_error_in <= 2'h0;
            endcase
            repeat (8) @(posedge clk_sys_in);
            chk(mf_pins_in[4], 1'b0);
            u_host.xfer(16'h1234, hr);
            repeat (4) @(posedge clk_sys_in);
            chk(mf_pins_in[4], 1'b1);
        end
        // masked: a valid change stays silent
        u_host.xfer(16'h0001, hr);
        @(posedge clk_sys_in);
        conversion_valid_flag_in <= 1'b0;
        repeat (8) @(posedge clk_sys_in);
        chk(mf_pins_in[4], 1'b1);
        power_down_n_in <= 1'b0;
        repeat (6) @(posedge clk_sys_in);
        chk(power_down_out, 1'b1);
        // leave power-down under reset, shortened from the settling time
        reset_n_in <= 1'b0;
        power_down_n_in <= 1'b1;
        repeat (12) @(posedge clk_sys_in);
        chk(mf_pins_oe_n_out, 8'hFF);
        reset_n_in <= 1'b1;
        repeat (1010) @(posedge clk_sys_in);
        chk(calibrating_out, 1'b0);
        apb(1'b1, 8'h00, 32'h1);
        repeat (3) @(posedge clk_sys_in);
        chk(calibrating_out, 1'b1);
        summarize();
    end
endmodule // tb
`default_nettype wire

// *** hw/mfp_pin_ctrl.v ***
// Decided for this implementation: the APB register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "mfp_regs.vh"

// Contract
// - modes one and two: pin four feeds parallel input bit four
// - mode three: pin four high drives frame sync and bit clock
// - mode four: select low shifts control in and status out
// - select rising latches the control word, held until next latch
// - control port works asynchronous to the audio port timing
// - mode four: open-drain active-low interrupt on pin five, maskable
// - interrupt on valid/bit-one change, clip rise, range error exit
// - modes one to three: pin five shows parallel output bit two
// - modes one to three: pin six feeds parallel input bit two
// - mode four: pin six is rate select as leader, frame size otherwise
// - mode four follower: format one high means slot select, low 32/64
// - modes one to three and mode four follower with pin six high: pins seven, eight pick slot
// - mode four leader: rate from pins six, seven, eight
// - reset release gives known state then calibration
// - power-down input low holds the power-down state
// - every mode: bit one input copied, bit one output driven
// - control data sampled on falling clock, changed on rising clock
module mfp_pin_ctrl (
    // clock and reset
    input  wire        clk_sys_in,
    input  wire        reset_n_in,
    // apb slave
    input  wire        psel_in,
    input  wire        penable_in,
    input  wire        pwrite_in,
    input  wire [7:0]  paddr_in,
    input  wire [31:0] pwdata_in,
    output reg  [31:0] prdata_out,
    output reg         pready_out,
    output reg         pslverr_out,
    // mode straps and power
    input  wire [1:0]  serial_mode_in,
    input  wire        mode_four_leader_in,
    input  wire        power_down_n_in,
    // multifunction pins, index 0 is pin one
    input  wire [7:0]  mf_pins_in,
    output reg  [7:0]  mf_pins_out,
    output reg  [7:0]  mf_pins_oe_n_out,
    // fixed parallel pins
    input  wire        parallel_in_bit_one_in,
    output reg         parallel_out_bit_one_out,
    // audio framer side, same clock
    input  wire [3:0]  rx_parallel_bits_in,
    output reg  [3:0]  tx_parallel_bits_out,
    input  wire        conversion_valid_flag_in,
    input  wire        left_clip_flag_in,
    input  wire        right_clip_flag_in,
    input  wire [1:0]  bit_clock_error_in,
    // configuration to the framer
    output reg         leader_mode_out,
    output reg         clock_sync_oe_n_out,
    output reg  [2:0]  rate_select_out,
    output reg  [1:0]  frame_size_out,
    output reg  [1:0]  slot_select_out,
    output reg  [15:0] control_word_out,
    output reg         calibrating_out,
    output reg         power_down_out
);

    wire [11:0] pins_s;
    wire [7:0]  mf_s;
    wire        di1_s;
    wire        pdn_n_s;
    wire        leader4_s;
    wire [1:0]  mode_s;
    reg         clk_prev_r;
    reg         sel_prev_r;
    reg  [15:0] shift_in_r;
    reg  [15:0] shift_out_r;
    reg  [15:0] status_word_r;
    reg  [31:0] ctrl_r;
    reg  [10:0] cal_cnt_r;
    reg         di1_prev_r;
    reg         adv_prev_r;
    reg         lcl_prev_r;
    reg         rcl_prev_r;
    reg  [1:0]  err_prev_r;
    reg         irq_pend_r;
    reg         irq_event;
    reg         irq_clear;
    reg         leader;
    wire        cp_fall;
    wire        cp_rise;
    wire        sel_rise;
    wire        sel_fall;
    wire        mode4;
    wire        apb_wr;
    wire        apb_rd;
    wire        recal;

    // all pin levels pass two flops first
    mfp_sync #(.W(12)) u_sync (
        .clk_sys_in (clk_sys_in),
        .reset_n_in (reset_n_in),
        .async_in   ({serial_mode_in, mode_four_leader_in, power_down_n_in,
                      parallel_in_bit_one_in, mf_pins_in[6:0]}),
        .sync_out   (pins_s)
    );

    // pin eight is folded in apart: the vector above keeps pins one to seven
    reg [1:0] mf8_meta_r;
    always @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            mf8_meta_r <= 2'h0;
        end else begin
            mf8_meta_r <= {mf8_meta_r[0], mf_pins_in[7]};
        end
    end

    assign mode_s    = pins_s[11:10];
    assign leader4_s = pins_s[9];
    assign pdn_n_s   = pins_s[8];
    assign di1_s     = pins_s[7];
    assign mf_s      = {mf8_meta_r[1], pins_s[6:0]};
    assign mode4     = (mode_s == `MFP_MODE_FOUR);

    // control port edges found on synchronised levels only
    assign cp_fall  = clk_prev_r & ~mf_s[2];
    assign cp_rise  = ~clk_prev_r & mf_s[2];
    assign sel_rise = ~sel_prev_r & mf_s[3];
    assign sel_fall = sel_prev_r & ~mf_s[3];
    assign apb_wr   = psel_in & penable_in & pwrite_in;
    assign apb_rd   = psel_in & ~penable_in & ~pwrite_in;
    assign recal    = apb_wr & (paddr_in == `MFP_OFS_CTRL) &
                      pwdata_in[`MFP_CTRL_RECAL_BIT];

    // sub-mode decode
    always @* begin
        case (mode_s)
            `MFP_MODE_THREE: leader = mf_s[3];
            `MFP_MODE_FOUR:  leader = leader4_s;
            default:         leader = 1'b0;
        endcase
    end

    // interrupt sources compared to their last values
    always @* begin
        irq_event = (conversion_valid_flag_in != adv_prev_r) |
                    (di1_s != di1_prev_r) |
                    (left_clip_flag_in & ~lcl_prev_r) |
                    (right_clip_flag_in & ~rcl_prev_r) |
                    ((err_prev_r == `MFP_ERR_RANGE) &&
                     (bit_clock_error_in != `MFP_ERR_RANGE));
        irq_clear = mode4 & sel_fall;
    end

    // edge history, control port shifting and latching
    always @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            clk_prev_r       <= 1'b0;
            sel_prev_r       <= 1'b1;
            shift_in_r       <= `MFP_CW_RESET;
            shift_out_r      <= `MFP_SW_RESET;
            control_word_out <= `MFP_CW_RESET;
        end else begin
            clk_prev_r <= mf_s[2];
            sel_prev_r <= mf_s[3];
            if (mode4 && !mf_s[3] && cp_fall) begin
                shift_in_r <= {shift_in_r[14:0], mf_s[1]};
            end
            if (mode4 && sel_fall) begin
                shift_out_r <= status_word_r;
            end else if (mode4 && !mf_s[3] && cp_rise) begin
                shift_out_r <= {shift_out_r[14:0], 1'b0};
            end
            if (mode4 && sel_rise) begin
                control_word_out <= shift_in_r;
            end
        end
    end

    // interrupt pending flag, a new event beats the clear
    always @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            irq_pend_r <= 1'b0;
            di1_prev_r <= 1'b0;
            adv_prev_r <= 1'b0;
            lcl_prev_r <= 1'b0;
            rcl_prev_r <= 1'b0;
            err_prev_r <= 2'h0;
        end else begin
            di1_prev_r <= di1_s;
            adv_prev_r <= conversion_valid_flag_in;
            lcl_prev_r <= left_clip_flag_in;
            rcl_prev_r <= right_clip_flag_in;
            err_prev_r <= bit_clock_error_in;
            if (mode4 && irq_event && !calibrating_out) begin
                irq_pend_r <= 1'b1;
            end else if (irq_clear || !mode4) begin
                irq_pend_r <= 1'b0;
            end
        end
    end

    // calibration after reset, recalibrate request or power-down
    always @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            cal_cnt_r       <= 11'h000;
            calibrating_out <= 1'b1;
            power_down_out  <= 1'b1;
        end else begin
            power_down_out <= ~pdn_n_s;
            if (!pdn_n_s || recal) begin
                cal_cnt_r       <= 11'h000;
                calibrating_out <= 1'b1;
            end else if (cal_cnt_r == `MFP_CAL_CYCLES - 1) begin
                calibrating_out <= 1'b0;
            end else begin
                cal_cnt_r <= cal_cnt_r + 11'h001;
            end
        end
    end

    // pin routing, every output from a flop
    always @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            mf_pins_out              <= 8'h00;
            mf_pins_oe_n_out         <= 8'hFF;
            parallel_out_bit_one_out <= 1'b0;
            tx_parallel_bits_out     <= 4'h0;
            leader_mode_out          <= 1'b0;
            clock_sync_oe_n_out      <= 1'b1;
            rate_select_out          <= 3'h0;
            frame_size_out           <= `MFP_FRAME_32;
            slot_select_out          <= 2'h0;
        end else begin
            mf_pins_out              <= 8'h00;
            mf_pins_oe_n_out         <= 8'hFF;
            parallel_out_bit_one_out <= rx_parallel_bits_in[0];
            tx_parallel_bits_out     <= {1'b0, 1'b0, 1'b0, di1_s};
            leader_mode_out          <= leader;
            clock_sync_oe_n_out      <= ~leader | power_down_out;
            rate_select_out          <= 3'h0;
            frame_size_out           <= `MFP_FRAME_64;
            slot_select_out          <= {mf_s[7], mf_s[6]};
            case (mode_s)
                `MFP_MODE_ONE, `MFP_MODE_TWO: begin
                    mf_pins_out[1:0]      <= {rx_parallel_bits_in[2],
                                              rx_parallel_bits_in[3]};
                    mf_pins_oe_n_out[1:0] <= 2'h0;
                    mf_pins_out[4]        <= rx_parallel_bits_in[1];
                    mf_pins_oe_n_out[4]   <= 1'b0;
                    tx_parallel_bits_out  <= {mf_s[3], mf_s[2], mf_s[5],
                                              di1_s};
                end
                `MFP_MODE_THREE: begin
                    mf_pins_out[4]       <= rx_parallel_bits_in[1];
                    mf_pins_oe_n_out[4]  <= 1'b0;
                    tx_parallel_bits_out <= {1'b0, leader ? 1'b0 : mf_s[2],
                                             mf_s[5], di1_s};
                    rate_select_out      <= leader ? {mf_s[2], mf_s[1], mf_s[0]}
                                                   : 3'h0;
                end
                `MFP_MODE_FOUR: begin
                    mf_pins_out[0]      <= shift_out_r[15];
                    mf_pins_oe_n_out[0] <= mf_s[3];
                    mf_pins_out[4]      <= 1'b0;
                    mf_pins_oe_n_out[4] <= ~(irq_pend_r &
                        ~control_word_out[`MFP_CW_MASK_BIT]);
                    if (leader) begin
                        rate_select_out <= {mf_s[7], mf_s[6], mf_s[5]};
                        frame_size_out  <= `MFP_FRAME_32;
                        slot_select_out <= 2'h0;
                    end else if (mf_s[5]) begin
                        frame_size_out  <= `MFP_FRAME_128;
                    end else begin
                        frame_size_out  <= mf_s[6] ? `MFP_FRAME_64
                                                   : `MFP_FRAME_32;
                        slot_select_out <= 2'h0;
                    end
                end
                default: begin
                    mf_pins_oe_n_out <= 8'hFF;
                end
            endcase
        end
    end

    // apb slave: zero wait, error on unmapped offsets
    always @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            ctrl_r        <= `MFP_CTRL_RESET;
            status_word_r <= `MFP_SW_RESET;
            prdata_out    <= 32'h0000_0000;
            pready_out    <= 1'b0;
            pslverr_out   <= 1'b0;
        end else begin
            pready_out  <= psel_in & ~penable_in;
            pslverr_out <= psel_in & ~penable_in &
                           (paddr_in != `MFP_OFS_CTRL) &&
                           (paddr_in != `MFP_OFS_STATUS) &&
                           (paddr_in != `MFP_OFS_CTRL_WORD) &&
                           (paddr_in != `MFP_OFS_STAT_WORD);
            if (apb_wr && paddr_in == `MFP_OFS_STAT_WORD) begin
                status_word_r <= pwdata_in[15:0];
            end
            if (apb_wr && paddr_in == `MFP_OFS_CTRL) begin
                ctrl_r <= pwdata_in;
            end
            if (apb_rd) begin
                case (paddr_in)
                    `MFP_OFS_CTRL:      prdata_out <= ctrl_r;
                    `MFP_OFS_STATUS:    prdata_out <= {26'h0, irq_pend_r,
                                            power_down_out, calibrating_out,
                                            leader, mode_s};
                    `MFP_OFS_CTRL_WORD: prdata_out <= {16'h0, control_word_out};
                    `MFP_OFS_STAT_WORD: prdata_out <= {16'h0, status_word_r};
                    default:            prdata_out <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule // mfp_pin_ctrl

`default_nettype wire

// *** hw/mfp_regs.vh ***
`ifndef MFP_REGS_VH
`define MFP_REGS_VH

// apb register byte offsets
`define MFP_OFS_CTRL        8'h00
`define MFP_OFS_STATUS      8'h04
`define MFP_OFS_CTRL_WORD   8'h08
`define MFP_OFS_STAT_WORD   8'h0C

// control register fields
`define MFP_CTRL_RECAL_BIT  0
`define MFP_CTRL_RESET      32'h0000_0000

// status register fields
`define MFP_ST_MODE_LSB     0
`define MFP_ST_LEADER_BIT   2
`define MFP_ST_CAL_BIT      3
`define MFP_ST_PDN_BIT      4
`define MFP_ST_IRQ_BIT      5

// serial mode codes
`define MFP_MODE_ONE        2'h0
`define MFP_MODE_TWO        2'h1
`define MFP_MODE_THREE      2'h2
`define MFP_MODE_FOUR       2'h3

// frame size codes
`define MFP_FRAME_32        2'h0
`define MFP_FRAME_64        2'h1
`define MFP_FRAME_128       2'h2

// control port word layout
`define MFP_CW_BITS         16
`define MFP_CW_MASK_BIT     0
`define MFP_CW_RESET        16'h0000
`define MFP_SW_RESET        16'h0000

// bit clock out-of-range error code
`define MFP_ERR_RANGE       2'h3

// calibration time in microseconds and the clock rate in mhz
`define MFP_CAL_TIME_US     8
`define MFP_CLK_MHZ         125
`define MFP_CAL_CYCLES      (`MFP_CAL_TIME_US * `MFP_CLK_MHZ)

`endif

// *** hw/mfp_sync.v ***
`timescale 1ns/1ns
`default_nettype none

// two-flop synchroniser for a group of levels
module mfp_sync #(
    parameter W = 1
) (
    // clock and reset
    input  wire         clk_sys_in,
    input  wire         reset_n_in,
    // levels
    input  wire [W-1:0] async_in,
    output reg  [W-1:0] sync_out
);

    reg [W-1:0] meta_r;

    // first stage read only by the second
    always @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            meta_r   <= {W{1'b0}};
            sync_out <= {W{1'b0}};
        end else begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end

endmodule // mfp_sync

`default_nettype wire
